// ---- src/rsfi_top.sv ----
// Purpose: Regulator enables, level decode, power-good and fault interrupt
// Assumes: Control bits come from a serial register file outside
// Notes: Interrupt clears only after a read strobe for the faulting flag
`timescale 1ns/1ps
module rsfi_top
  import rsfi_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [NUM_REG-1:0] pgoodRaw,
  input wire logic [NUM_BUCK-1:0] buckOn,
  input wire logic [NUM_LDO-1:0] ldoOn,
  input wire logic [NUM_LDO-1:0] dischargeEnable,
  input wire logic [NUM_REG-1:0] faultIrqUnmask,
  input wire logic [NUM_REG-1:0] okRead,
  input wire logic levelBankSelect,
  input wire logic [CODE_W-1:0] levelCodeBankA [NUM_BUCK],
  input wire logic [CODE_W-1:0] levelCodeBankB [1:NUM_BUCK-1],
  input wire logic [NUM_LDO-1:0] ldoCodeWrEn,
  input wire logic [CODE_W-1:0] ldoCodeWrData,
  output logic [NUM_REG-1:0] powerGood,
  output logic [NUM_REG-1:0] regEnable,
  output logic [NUM_LDO-1:0] dischargeOn,
  output logic [CODE_W-1:0] ldoLevelCode [NUM_LDO],
  output logic [MV_W-1:0] targetMv [NUM_REG],
  output logic [NUM_REG-1:0] faultPending,
  output logic faultRequestLine_n
);
  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_REG-1:0] pgSync;
  logic [NUM_REG-1:0] pgPrev_r;
  logic [NUM_REG-1:0] fallEv;
  logic [NUM_REG-1:0] trig;
  logic [NUM_REG-1:0] clearOk;
  rsfi_flt_t flt_r [NUM_REG];
  rsfi_flt_t flt_nxt [NUM_REG];
  logic [NUM_REG-1:0] powerGood_nxt;
  logic [NUM_REG-1:0] regEnable_nxt;
  logic [NUM_LDO-1:0] dischargeOn_nxt;
  logic [CODE_W-1:0] ldoCode_nxt [NUM_LDO];
  logic [MV_W-1:0] targetMv_nxt [NUM_REG];
  logic [NUM_REG-1:0] pending_nxt;
  logic line_nxt;

  rsfi_sync #(.W(NUM_REG)) u_pg_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(pgoodRaw),
    .dout(pgSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control, level decode and status
  always_comb
  begin
    powerGood_nxt = pgSync; // [RULE_01] [RULE_02]
    regEnable_nxt = {ldoOn, buckOn}; // [RULE_08] [RULE_10]
    // Tracks the enable input, so discharge never overlaps an enable
    dischargeOn_nxt = dischargeEnable & ~ldoOn; // [RULE_09]
    for (int i = 0; i < NUM_LDO; i++)
    begin
      ldoCode_nxt[i] = ldoCodeWrEn[i] ? ldoCodeWrData
                                      : ldoLevelCode[i]; // [RULE_07]
      targetMv_nxt[LDO_BASE+i] = level_mv(ldoLevelCode[i]); // [RULE_06]
    end
    targetMv_nxt[0] = level_mv(levelCodeBankA[0]);
    for (int i = 1; i < NUM_BUCK; i++)
    begin
      targetMv_nxt[i] = level_mv(levelCodeBankA[i]);
      if (levelBankSelect)
      begin
        targetMv_nxt[i] = level_mv(levelCodeBankB[i]); // [RULE_11]
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      powerGood <= '0;
      regEnable <= '0;
      dischargeOn <= '0;
      ldoLevelCode <= LDO_CODE_DEFAULT;
      for (int i = 0; i < NUM_REG; i++)
      begin
        targetMv[i] <= MV_MIN;
      end
    end
    else
    begin
      powerGood <= powerGood_nxt;
      regEnable <= regEnable_nxt;
      dischargeOn <= dischargeOn_nxt;
      ldoLevelCode <= ldoCode_nxt;
      targetMv <= targetMv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault tracking per regulator
  // Only a falling edge while enabled counts, so switching off is no fault
  assign fallEv = pgPrev_r & ~pgSync;
  assign trig = fallEv & regEnable & faultIrqUnmask; // [RULE_03] [RULE_04]
  assign clearOk = ~regEnable | pgSync;

  always_comb
  begin
    for (int i = 0; i < NUM_REG; i++)
    begin
      flt_nxt[i] = flt_r[i];
      // New fault always wins over a clear in the same cycle
      case (flt_r[i])
        FLT_IDLE:
        begin
          if (trig[i])
          begin
            flt_nxt[i] = FLT_PEND;
          end
        end
        FLT_PEND:
        begin
          if (okRead[i] && !trig[i])
          begin
            flt_nxt[i] = FLT_READ;
          end
        end
        FLT_READ:
        begin
          if (trig[i])
          begin
            flt_nxt[i] = FLT_PEND;
          end
          else if (clearOk[i])
          begin
            flt_nxt[i] = FLT_IDLE; // [RULE_05]
          end
        end
        default:
        begin
          flt_nxt[i] = FLT_IDLE;
        end
      endcase
      pending_nxt[i] = (flt_nxt[i] != FLT_IDLE);
    end
    line_nxt = ~|pending_nxt; // [RULE_12]
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pgPrev_r <= '0;
      faultPending <= '0;
      faultRequestLine_n <= 1'b1;
      for (int i = 0; i < NUM_REG; i++)
      begin
        flt_r[i] <= FLT_IDLE;
      end
    end
    else
    begin
      pgPrev_r <= pgSync;
      faultPending <= pending_nxt;
      faultRequestLine_n <= line_nxt;
      flt_r <= flt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_buck_pg_low;
    !pgoodRaw[0] [*3] |=> !powerGood[0];
  endproperty
  a_buck_pg_low: assert property (p_buck_pg_low) // [RULE_01]
    else $error("converter power-good not low");

  property p_ldo_pg_high;
    pgoodRaw[LDO_BASE] [*3] |=> powerGood[LDO_BASE];
  endproperty
  a_ldo_pg_high: assert property (p_ldo_pg_high) // [RULE_02]
    else $error("regulator power-good not high");

  property p_buck_irq;
    fallEv[1] && regEnable[1] && faultIrqUnmask[1] |-> ##1 !faultRequestLine_n;
  endproperty
  a_buck_irq: assert property (p_buck_irq) // [RULE_03]
    else $error("converter fault did not assert interrupt");

  property p_ldo_irq;
    fallEv[5] && regEnable[5] && faultIrqUnmask[5]
      |-> ##1 faultPending[5] && !faultRequestLine_n;
  endproperty
  a_ldo_irq: assert property (p_ldo_irq) // [RULE_04]
    else $error("regulator fault did not assert interrupt");

  property p_hold_unread;
    faultPending[5] && !okRead[5] && flt_r[5] == FLT_PEND |=> faultPending[5];
  endproperty
  a_hold_unread: assert property (p_hold_unread) // [RULE_05]
    else $error("fault cleared without a read");

  property p_clear_cause;
    $fell(faultPending[1])
      |-> $past(clearOk[1]) && $past(flt_r[1]) == FLT_READ;
  endproperty
  a_clear_cause: assert property (p_clear_cause) // [RULE_05]
    else $error("fault cleared without cause");

  property p_decode_max;
    ldoCodeWrEn[0] && ldoCodeWrData == CODE_MAX
      |-> ##2 targetMv[LDO_BASE] == MV_MAX;
  endproperty
  a_decode_max: assert property (p_decode_max) // [RULE_06]
    else $error("top level code not decoded to maximum");

  property p_decode_min;
    ldoCodeWrEn[1] && ldoCodeWrData == CODE_MIN
      |-> ##2 targetMv[LDO_BASE+1] == MV_MIN;
  endproperty
  a_decode_min: assert property (p_decode_min) // [RULE_06]
    else $error("bottom level code not decoded to minimum");

  property p_code_keep;
    !ldoCodeWrEn[2] |=> $stable(ldoLevelCode[2]);
  endproperty
  a_code_keep: assert property (p_code_keep) // [RULE_07]
    else $error("level code changed without write");

  property p_ldo_on;
    ldoOn[3] |=> regEnable[LDO_BASE+3];
  endproperty
  a_ldo_on: assert property (p_ldo_on) // [RULE_08]
    else $error("regulator enable not followed");

  property p_discharge;
    dischargeOn[0] |-> !regEnable[LDO_BASE];
  endproperty
  a_discharge: assert property (p_discharge) // [RULE_09]
    else $error("discharge applied to an enabled regulator");

  property p_buck_off;
    !buckOn[2] [*2] |=> !regEnable[2];
  endproperty
  a_buck_off: assert property (p_buck_off) // [RULE_10]
    else $error("converter enable not followed");

  property p_bank_b;
    levelBankSelect |=> targetMv[3] == level_mv($past(levelCodeBankB[3]));
  endproperty
  a_bank_b: assert property (p_bank_b) // [RULE_11]
    else $error("bank B code not used");

  property p_line_idle;
    faultPending == '0 |-> faultRequestLine_n;
  endproperty
  a_line_idle: assert property (p_line_idle) // [RULE_12]
    else $error("interrupt low with nothing pending");
endmodule : rsfi_top

// ---- src/rsfi_pkg.sv ----
// Purpose: Shared constants for regulator status and fault interrupt logic
// Assumes: Four step-down converters, eight switchable linear regulators
// Notes: Index 0..3 are converters, 4..11 are linear regulators
//
// How it works
// [RULE_01] Each converter has a power-good flag that reads 0 while its output is below about 7% under target.
// [RULE_02] Each linear regulator has a power-good flag that reads 0 while its output is below about 11% under target.
// [RULE_03] An unmasked converter whose output drops below threshold raises the interrupt.
// [RULE_04] An unmasked linear regulator whose output drops below threshold raises the interrupt.
// [RULE_05] The interrupt stays low until the faulting regulator is off or in regulation and its flag was read.
// [RULE_06] A 6-bit level code, column in the upper three bits and row in the lower three, selects one of 64 levels from 0.600 V to 3.900 V.
// [RULE_07] Linear regulator level codes reset to factory defaults and may be rewritten afterwards.
// [RULE_08] Each linear regulator is switched on or off by its enable bit.
// [RULE_09] A disabled linear regulator with its discharge bit at 1 has its output pulled to ground, never otherwise.
// [RULE_10] Each converter is switched on or off by its enable bit.
// [RULE_11] Converters two to four use bank A codes while bank select is low and bank B codes while it is high.
// [RULE_12] The single interrupt line is low while any regulator has an unmasked fault not yet cleared.
// [RULE_13] Power-good comparator outputs are synchronised to the clock before any use.
package rsfi_pkg;
  localparam int NUM_BUCK = 4;
  localparam int NUM_LDO = 8;
  localparam int NUM_REG = 12;
  localparam int CODE_W = 6;
  localparam int MV_W = 12;
  localparam int LDO_BASE = 4;
  // Analog thresholds, informative only
  localparam int BUCK_PG_PCT = 7;
  localparam int LDO_PG_PCT = 11;

  localparam logic [MV_W-1:0] COL_BASE_MV [8] = '{
    12'h258, 12'h320, 12'h3e8, 12'h4b0,
    12'h640, 12'h7d0, 12'h960, 12'hc80};
  localparam logic [MV_W-1:0] COL_STEP_MV [8] = '{
    12'h019, 12'h019, 12'h019, 12'h032,
    12'h032, 12'h032, 12'h064, 12'h064};
  localparam logic [MV_W-1:0] MV_MIN = 12'h258;
  localparam logic [MV_W-1:0] MV_MAX = 12'hf3c;
  localparam logic [CODE_W-1:0] CODE_MIN = 6'h00;
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h3f;

  // Factory level codes for the linear regulators
  localparam logic [CODE_W-1:0] LDO_CODE_DEFAULT [NUM_LDO] = '{
    6'h24, 6'h24, 6'h39, 6'h39, 6'h39, 6'h24, 6'h34, 6'h24};

  typedef enum logic [2:0] {
    FLT_IDLE = 3'b001,
    FLT_PEND = 3'b010,
    FLT_READ = 3'b100
  } rsfi_flt_t;

  function automatic logic [MV_W-1:0] level_mv(
    input logic [CODE_W-1:0] code);
    logic [2:0] col;
    logic [2:0] row;
    col = code[5:3];
    row = code[2:0];
    level_mv = COL_BASE_MV[col]
      + MV_W'(COL_STEP_MV[col] * MV_W'(row)); // [RULE_06]
  endfunction : level_mv
endpackage : rsfi_pkg

// ---- src/rsfi_sync.sv ----
// Purpose: Two-stage synchroniser for asynchronous comparator levels
// Assumes: Inputs are slow levels
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module rsfi_sync
  import rsfi_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else
    begin
      meta_r <= din; // [RULE_13]
      dout <= meta_r;
    end
  end
endmodule : rsfi_sync

// ---- dv/rsfi_host_model.sv ----
// Purpose: Processor model that reads power-good flags on an interrupt
// Assumes: Every pending flag is read once per low period of the line
// Notes: DLY sets how slowly the processor answers
`timescale 1ns/1ps
module rsfi_host_model
  import rsfi_pkg::*;
#(
  parameter int DLY = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic active,
  input wire logic lineN,
  input wire logic [NUM_REG-1:0] pending,
  output logic [NUM_REG-1:0] okRead
);
  int waitCnt_r;
  logic done_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitCnt_r <= 0;
      done_r <= 1'b0;
      okRead <= '0;
    end
    else
    begin
      okRead <= '0;
      if (lineN)
      begin
        waitCnt_r <= 0;
        done_r <= 1'b0;
      end
      else if (active && !done_r)
      begin
        // One read per interrupt, a held-low line is not re-read
        if (waitCnt_r == DLY)
        begin
          okRead <= pending;
          done_r <= 1'b1;
        end
        else
          waitCnt_r <= waitCnt_r + 1;
      end
    end
  end
endmodule : rsfi_host_model

// ---- dv/rsfi_top_test.sv ----
// Purpose: Self-checking bench for regulator status and fault logic
// Assumes: Host model reads the flags after the line falls
// Notes: Fixed waits cover the two-flop sync plus output registers
`timescale 1ns/1ps
module rsfi_top_test
  import rsfi_pkg::*;
;
  localparam int BASE [8] = '{600, 800, 1000, 1200, 1600, 2000, 2400, 3200};
  localparam int STEP [8] = '{25, 25, 25, 50, 50, 50, 100, 100};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hostOn = 1'b0;
  logic levelBankSelect = 1'b0;
  logic [NUM_REG-1:0] pgoodRaw = '0, faultIrqUnmask = '0, okRead;
  logic [NUM_REG-1:0] powerGood, regEnable, faultPending;
  logic [NUM_BUCK-1:0] buckOn = '0;
  logic [NUM_LDO-1:0] ldoOn = '0, dischargeEnable = 8'hff, ldoCodeWrEn = '0;
  logic [NUM_LDO-1:0] dischargeOn;
  logic [CODE_W-1:0] ldoCodeWrData = '0;
  logic [CODE_W-1:0] levelCodeBankA [NUM_BUCK] = '{default: 6'h00};
  logic [CODE_W-1:0] levelCodeBankB [1:NUM_BUCK-1] = '{default: 6'h00};
  logic [CODE_W-1:0] ldoLevelCode [NUM_LDO];
  logic [MV_W-1:0] targetMv [NUM_REG];
  logic faultRequestLine_n;
  int bad_count = 0;
  int compares = 0;

  always #12.5 clk = ~clk;

  rsfi_top i_rsfi_top (.clk, .arst_n, .pgoodRaw, .buckOn, .ldoOn,
    .dischargeEnable, .faultIrqUnmask, .okRead, .levelBankSelect,
    .levelCodeBankA, .levelCodeBankB, .ldoCodeWrEn, .ldoCodeWrData,
    .powerGood, .regEnable, .dischargeOn, .ldoLevelCode, .targetMv,
    .faultPending, .faultRequestLine_n);

  rsfi_host_model #(.DLY(3)) i_rsfi_host_model (.clk, .arst_n,
    .active(hostOn), .lineN(faultRequestLine_n), .pending(faultPending),
    .okRead);

  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Outputs settle after the edge's updates land
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic wait_line(input logic lvl);
    for (int i = 0; i < 40 && faultRequestLine_n !== lvl; i++)
      @(posedge clk);
    #1;
  endtask : wait_line

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(6);
    arst_n <= 1'b1;
    #1;
    chk(faultRequestLine_n, 1);
    chk(powerGood, 0);
    for (int i = 0; i < NUM_LDO; i++)
      chk(ldoLevelCode[i], LDO_CODE_DEFAULT[i]);
    settle(3);
    chk(dischargeOn, 8'hff);
    tick(1);
    dischargeEnable <= 8'h0f;
    buckOn <= 4'hf;
    ldoOn <= 8'hf0;
    settle(3);
    chk(regEnable, 12'hf0f);
    chk(dischargeOn, 8'h0f);
    // Walk every column, row equal to column, covering both ends
    for (int c = 0; c < 8; c++)
    begin
      tick(1);
      levelCodeBankA[0] <= 6'(c * 9);
      settle(2);
      chk(targetMv[0], BASE[c] + STEP[c] * c);
    end
    tick(1);
    levelCodeBankB[1] <= 6'h3f;
    levelBankSelect <= 1'b1;
    settle(2);
    chk(targetMv[1], 3900);
    tick(1);
    levelBankSelect <= 1'b0;
    settle(2);
    chk(targetMv[1], 600);
    tick(1);
    ldoCodeWrEn <= 8'h01;
    ldoCodeWrData <= 6'h3f;
    tick(1);
    ldoCodeWrEn <= 8'h80;
    ldoCodeWrData <= 6'h08;
    tick(1);
    ldoCodeWrEn <= 8'h02;
    ldoCodeWrData <= 6'h00;
    tick(1);
    ldoCodeWrEn <= 8'h00;
    settle(3);
    chk(ldoLevelCode[0], 6'h3f);
    chk(ldoLevelCode[7], 6'h08);
    chk(targetMv[4], 3900);
    chk(targetMv[11], 800);
    chk(ldoLevelCode[1], 6'h00);
    chk(targetMv[5], 600);
    tick(1);
    ldoOn <= 8'hff;
    pgoodRaw <= 12'hfff;
    faultIrqUnmask <= 12'h020;
    settle(5);
    chk(powerGood, 12'hfff);
    chk(dischargeOn, 8'h00);
    // Masked converter and unmasked linear regulator drop together
    tick(1);
    pgoodRaw <= 12'hfdb;
    settle(6);
    chk(powerGood, 12'hfdb);
    chk(faultPending, 12'h020);
    chk(faultRequestLine_n, 0);
    tick(1);
    pgoodRaw <= 12'hfff;
    settle(8);
    chk(faultPending, 12'h020);
    tick(1);
    hostOn <= 1'b1;
    wait_line(1'b1);
    chk(faultPending, 0);
    // Read while still faulting must not clear
    tick(1);
    faultIrqUnmask <= 12'h002;
    pgoodRaw <= 12'hffd;
    wait_line(1'b0);
    chk(faultPending, 12'h002);
    settle(12);
    chk(faultRequestLine_n, 0);
    tick(1);
    buckOn <= 4'hd;
    wait_line(1'b1);
    chk(faultPending, 0);
    report_and_stop;
  end

  initial
  begin
    #(3000 * 25);
    bad_count++;
    report_and_stop;
  end
endmodule : rsfi_top_test
